// >>> logic/bit_sampler.sv
// bit sampler: single sample or majority of three at the sample point
`timescale 1ns/100ps
`default_nettype none
module bit_sampler (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // timing strobes
  input wire logic tq_tick,
  input wire logic in_seg_one,
  input wire logic take,
  input wire logic triple,
  // synchronised bus level
  input wire logic rx,
  // sampled bit
  output logic bit_value,
  output logic bit_valid
);

  typedef struct packed {
    logic [1:0] hist;
    logic value;
    logic valid;
  } state_s;

  state_s st_reg;
  state_s st_next;
  logic vote;

  // majority of two earlier quanta and the sample point
  assign vote = (st_reg.hist[1] & st_reg.hist[0]) | (st_reg.hist[1] & rx) |
                (st_reg.hist[0] & rx);

  ////////////////////////////////////////////////////////////////////////////
  // history needs two quanta of phase one before the point
  always_comb begin
    st_next = st_reg;
    st_next.valid = 1'b0;
    if (tq_tick && in_seg_one) begin
      st_next.hist = {st_reg.hist[0], rx};
    end
    if (take) begin
      st_next.value = triple ? vote : rx;
      st_next.valid = 1'b1;
    end
  end

  assign bit_value = st_reg.value;
  assign bit_valid = st_reg.valid;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= 4'he; // history and value recessive, no false valid pulse
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_single;
    @(posedge clk) disable iff (rst)
    take && !triple |=> bit_valid && bit_value == $past(rx);
  endproperty
  a_single: assert property (p_single) else $error("single sample wrong");

  property p_majority;
    @(posedge clk) disable iff (rst)
    take && triple |=> bit_valid && bit_value == $past(vote);
  endproperty
  a_majority: assert property (p_majority) else $error("majority vote wrong");

endmodule : bit_sampler
`default_nettype wire

// >>> logic/can_bit_timing_mode_handshake.sv
// can bit timing, mode handshake and configuration registers on apb
//
// Summary of operation
// - sleep ack rises once sleep is entered; sleep is request and ack both set
// - bus activity while asleep clears sleep ack when wake-up is enabled
// - init ack follows init request; init mode is request and ack both set
// - control one, timing, acceptance registers writable only in init mode
// - jump width code 0 to 3 limits resync to 1 to 4 quanta
// - prescaler divides module clock by field value plus one, 1 to 64
// - single sample mode takes the bus level at the sample point
// - triple sample mode takes majority of three samples
// - segment two lasts field plus one quanta; zero code invalid
// - segment one lasts field plus one quanta; codes 0 to 2 invalid
// - bit time follows module clock, prescaler and quanta per bit
// - software cannot clear sleep request before sleep is acknowledged
// - software cannot clear init request before init is acknowledged
// - transmit pin goes recessive at once when init is requested
// - clock select bit picks oscillator at 0, bus clock at 1
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module can_bit_timing_mode_handshake (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // oscillator clock enable, same clock domain
  input wire logic OSC_TICK,
  // can pins
  input wire logic CAN_RX,
  output logic CAN_TX,
  // frame logic side
  input wire logic TX_BIT,
  output logic RX_BIT,
  output logic RX_BIT_VALID,
  output logic BIT_START,
  output logic INIT_ACTIVE,
  output logic SLEEP_ACTIVE
);

  typedef struct packed {
    logic sleep_request;
    logic init_request;
    logic wakeup_enable;
    logic sleep_ack;
    logic init_ack;
    logic clock_select;
    logic [7:0] timing_zero;
    logic [7:0] timing_one;
    logic [7:0] acc_control;
    logic [7:0][7:0] codes;
    logic [7:0][7:0] masks;
    logic rx_meta;
    logic rx_sync;
    logic rx_prev;
    can_timing_pkg::phase_e phase;
    logic [4:0] cnt;
    logic [2:0] ext;
    logic [2:0] shrink;
    logic [31:0] prdata;
    logic tx;
    logic bit_start;
  } state_s;

  localparam state_s RESET_STATE = '{
    sleep_request: can_timing_pkg::RESET_SLEEP_REQ,
    init_request: can_timing_pkg::RESET_INIT_REQ,
    wakeup_enable: can_timing_pkg::RESET_WAKEUP_EN,
    sleep_ack: 1'b0,
    init_ack: can_timing_pkg::RESET_INIT_REQ,
    clock_select: can_timing_pkg::RESET_CLOCK_SEL,
    timing_zero: can_timing_pkg::RESET_TIMING_ZERO,
    timing_one: can_timing_pkg::RESET_TIMING_ONE,
    acc_control: can_timing_pkg::RESET_FILTER,
    codes: {8{can_timing_pkg::RESET_FILTER}},
    masks: {8{can_timing_pkg::RESET_FILTER}},
    rx_meta: can_timing_pkg::RECESSIVE,
    rx_sync: can_timing_pkg::RECESSIVE,
    rx_prev: can_timing_pkg::RECESSIVE,
    phase: can_timing_pkg::PH_SYNC,
    cnt: 5'h00,
    ext: 3'h0,
    shrink: 3'h0,
    prdata: 32'h0000_0000,
    tx: can_timing_pkg::RECESSIVE,
    bit_start: 1'b0
  };

  state_s st_reg;
  state_s st_next;

  logic init_active;
  logic sleep_active;
  logic halt;
  logic fall;
  logic wake;
  logic mclk_en;
  logic tq_tick;
  logic take;
  logic is_code;
  logic is_mask;
  logic mapped;
  logic wr_en;
  logic [31:0] rd_data;
  logic [5:0] presc;
  logic [2:0] jump_q;
  logic [4:0] seg1_len;
  logic [3:0] seg2_len;
  logic [4:0] seg2_left;
  logic [4:0] late_err;
  logic seg1_last;
  logic seg2_last;
  logic [11:0] bit_len;

  ////////////////////////////////////////////////////////////////////////////
  // mode status and bus events
  assign init_active = st_reg.init_request & st_reg.init_ack;
  assign sleep_active = st_reg.sleep_request & st_reg.sleep_ack;
  // engine stops the moment init is requested, not only once acked
  assign halt = st_reg.init_request | sleep_active;
  // recessive to dominant edge seen after the synchroniser
  assign fall = (st_reg.rx_prev == can_timing_pkg::RECESSIVE) &&
                (st_reg.rx_sync != can_timing_pkg::RECESSIVE);
  assign wake = sleep_active & st_reg.wakeup_enable & fall;
  assign mclk_en = st_reg.clock_select ? 1'b1 : OSC_TICK;

  ////////////////////////////////////////////////////////////////////////////
  // field decode and segment arithmetic
  assign presc = st_reg.timing_zero[can_timing_pkg::PRESC_MSB:can_timing_pkg::PRESC_LSB];
  assign jump_q = {1'b0, st_reg.timing_zero[can_timing_pkg::JUMP_MSB:can_timing_pkg::JUMP_LSB]}
                  + 3'h1;
  assign seg1_len = {1'b0, st_reg.timing_one[can_timing_pkg::SEG1_MSB:can_timing_pkg::SEG1_LSB]}
                    + 5'h01 + {2'b00, st_reg.ext};
  assign seg2_len = {1'b0, st_reg.timing_one[can_timing_pkg::SEG2_MSB:can_timing_pkg::SEG2_LSB]}
                    + 4'h1 - {1'b0, st_reg.shrink};
  assign seg2_left = {1'b0, seg2_len} - st_reg.cnt;
  assign late_err = st_reg.cnt + 5'h01;
  assign seg1_last = (st_reg.cnt == seg1_len - 5'h01);
  // >= so a shortened segment two still ends
  assign seg2_last = (st_reg.cnt >= {1'b0, seg2_len} - 5'h01);
  assign take = tq_tick && !halt && (st_reg.phase == can_timing_pkg::PH_SEG_ONE) && seg1_last;
  // module clocks per bit, shown for software
  assign bit_len = 12'(({1'b0, presc} + 7'h01) *
                   ({1'b0, st_reg.timing_one[can_timing_pkg::SEG1_MSB:can_timing_pkg::SEG1_LSB]}
                   + {2'b00, st_reg.timing_one[can_timing_pkg::SEG2_MSB:can_timing_pkg::SEG2_LSB]}
                   + 5'h03));

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  assign is_code = (PADDR[7:5] == can_timing_pkg::OFS_CODE_BASE[7:5]) && (PADDR[1:0] == 2'b00);
  assign is_mask = (PADDR[7:5] == can_timing_pkg::OFS_MASK_BASE[7:5]) && (PADDR[1:0] == 2'b00);
  assign wr_en = PSEL & PENABLE & PWRITE & mapped;

  // read mux, reserved bits read as zero
  always_comb begin
    rd_data = 32'h0000_0000;
    mapped = 1'b1;
    if (PADDR == can_timing_pkg::OFS_CONTROL_ZERO) begin
      rd_data[can_timing_pkg::SLEEP_REQ_BIT] = st_reg.sleep_request;
      rd_data[can_timing_pkg::INIT_REQ_BIT] = st_reg.init_request;
      rd_data[can_timing_pkg::WAKEUP_EN_BIT] = st_reg.wakeup_enable;
    end else if (PADDR == can_timing_pkg::OFS_CONTROL_ONE) begin
      rd_data[can_timing_pkg::INIT_ACK_BIT] = st_reg.init_ack;
      rd_data[can_timing_pkg::SLEEP_ACK_BIT] = st_reg.sleep_ack;
      rd_data[can_timing_pkg::CLOCK_SEL_BIT] = st_reg.clock_select;
    end else if (PADDR == can_timing_pkg::OFS_TIMING_ZERO) begin
      rd_data[7:0] = st_reg.timing_zero;
    end else if (PADDR == can_timing_pkg::OFS_TIMING_ONE) begin
      rd_data[7:0] = st_reg.timing_one;
    end else if (PADDR == can_timing_pkg::OFS_ACC_CONTROL) begin
      rd_data[7:0] = st_reg.acc_control;
    end else if (PADDR == can_timing_pkg::OFS_BIT_LENGTH) begin
      rd_data[11:0] = bit_len;
    end else if (is_code) begin
      rd_data[7:0] = st_reg.codes[PADDR[4:2]];
    end else if (is_mask) begin
      rd_data[7:0] = st_reg.masks[PADDR[4:2]];
    end else begin
      mapped = 1'b0;
    end
  end

  // zero wait states; error only on unmapped access phase
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & !mapped;

  ////////////////////////////////////////////////////////////////////////////
  // next state of registers, handshake and bit engine
  always_comb begin
    st_next = st_reg;
    st_next.bit_start = 1'b0;
    // two-stage synchroniser, then edge history
    st_next.rx_meta = CAN_RX;
    st_next.rx_sync = st_reg.rx_meta;
    st_next.rx_prev = st_reg.rx_sync;
    // read data captured in setup, held through access
    if (PSEL && !PENABLE) begin
      st_next.prdata = rd_data;
    end
    if (wr_en && PADDR == can_timing_pkg::OFS_CONTROL_ZERO) begin
      st_next.wakeup_enable = PWDATA[can_timing_pkg::WAKEUP_EN_BIT];
      st_next.sleep_request = PWDATA[can_timing_pkg::SLEEP_REQ_BIT] |
                              (st_reg.sleep_request & !st_reg.sleep_ack);
      st_next.init_request = PWDATA[can_timing_pkg::INIT_REQ_BIT] |
                             (st_reg.init_request & !st_reg.init_ack);
    end
    // protected registers, silently dropped outside init mode
    if (wr_en && init_active) begin
      if (PADDR == can_timing_pkg::OFS_CONTROL_ONE) begin
        st_next.clock_select = PWDATA[can_timing_pkg::CLOCK_SEL_BIT];
      end
      if (PADDR == can_timing_pkg::OFS_TIMING_ZERO) begin
        st_next.timing_zero = PWDATA[7:0];
      end
      if (PADDR == can_timing_pkg::OFS_TIMING_ONE) begin
        st_next.timing_one = PWDATA[7:0];
      end
      if (PADDR == can_timing_pkg::OFS_ACC_CONTROL) begin
        st_next.acc_control = PWDATA[7:0];
      end
      if (is_code) begin
        st_next.codes[PADDR[4:2]] = PWDATA[7:0];
      end
      if (is_mask) begin
        st_next.masks[PADDR[4:2]] = PWDATA[7:0];
      end
    end
    // init ack trails the request by one cycle
    st_next.init_ack = st_reg.init_request;
    // sleep is entered only at a bit boundary with an idle bus
    if (!st_reg.sleep_request) begin
      st_next.sleep_ack = 1'b0;
    end else if (!st_reg.sleep_ack && st_reg.rx_sync == can_timing_pkg::RECESSIVE &&
                 (st_reg.phase == can_timing_pkg::PH_SYNC || init_active)) begin
      st_next.sleep_ack = 1'b1;
    end
    if (wake) begin
      st_next.sleep_ack = 1'b0;
      st_next.sleep_request = 1'b0;
    end
    // bit engine
    if (halt) begin
      st_next.phase = can_timing_pkg::PH_SYNC;
      st_next.cnt = 5'h00;
      st_next.ext = 3'h0;
      st_next.shrink = 3'h0;
    end else begin
      if (tq_tick) begin
        unique case (st_reg.phase)
          can_timing_pkg::PH_SYNC: begin
            st_next.phase = can_timing_pkg::PH_SEG_ONE;
            st_next.cnt = 5'h00;
            st_next.ext = 3'h0;
            st_next.shrink = 3'h0;
          end
          can_timing_pkg::PH_SEG_ONE: begin
            if (seg1_last) begin
              st_next.phase = can_timing_pkg::PH_SEG_TWO;
              st_next.cnt = 5'h00;
            end else begin
              st_next.cnt = st_reg.cnt + 5'h01;
            end
          end
          can_timing_pkg::PH_SEG_TWO: begin
            if (seg2_last) begin
              st_next.phase = can_timing_pkg::PH_SYNC;
              st_next.cnt = 5'h00;
              st_next.bit_start = 1'b1;
            end else begin
              st_next.cnt = st_reg.cnt + 5'h01;
            end
          end
          default: begin
            st_next.phase = can_timing_pkg::PH_SYNC;
          end
        endcase
      end
      // resync: late edge lengthens phase one, early edge cuts phase two
      if (fall && st_reg.phase == can_timing_pkg::PH_SEG_ONE) begin
        st_next.ext = (late_err > {2'b00, jump_q}) ? jump_q : late_err[2:0];
      end else if (fall && st_reg.phase == can_timing_pkg::PH_SEG_TWO) begin
        if (seg2_left <= {2'b00, jump_q}) begin
          st_next.phase = can_timing_pkg::PH_SEG_ONE;
          st_next.cnt = 5'h00;
          st_next.ext = 3'h0;
        end else begin
          st_next.shrink = jump_q;
        end
      end
    end
    // recessive in the same edge that latches the request
    st_next.tx = (st_next.init_request | st_next.sleep_ack) ?
                 can_timing_pkg::RECESSIVE : TX_BIT;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_reg <= RESET_STATE;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // quantum clock and sampling
  quantum_prescaler u_prescaler (
    .clk(CLK),
    .rst(RST),
    .clear(halt),
    .mclk_en(mclk_en),
    .divide(presc),
    .tq_tick(tq_tick)
  );

  bit_sampler u_sampler (
    .clk(CLK),
    .rst(RST),
    .tq_tick(tq_tick),
    .in_seg_one(st_reg.phase == can_timing_pkg::PH_SEG_ONE),
    .take(take),
    .triple(st_reg.timing_one[can_timing_pkg::TRIPLE_BIT]),
    .rx(st_reg.rx_sync),
    .bit_value(RX_BIT),
    .bit_valid(RX_BIT_VALID)
  );

  // outputs
  assign PRDATA = st_reg.prdata;
  assign CAN_TX = st_reg.tx;
  assign BIT_START = st_reg.bit_start;
  assign INIT_ACTIVE = init_active;
  assign SLEEP_ACTIVE = sleep_active;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  property p_init_ack;
    $rose(st_reg.init_request) |=> st_reg.init_ack ##1 INIT_ACTIVE;
  endproperty
  a_init_ack: assert property (p_init_ack) else $error("init ack missing");

  property p_tx_recessive;
    st_reg.init_request |-> CAN_TX == can_timing_pkg::RECESSIVE;
  endproperty
  a_tx_recessive: assert property (p_tx_recessive) else $error("tx not recessive");

  property p_write_gate;
    PSEL && PENABLE && PWRITE && !INIT_ACTIVE &&
    (PADDR == can_timing_pkg::OFS_TIMING_ZERO || PADDR == can_timing_pkg::OFS_TIMING_ONE)
    |=> $stable(st_reg.timing_zero) && $stable(st_reg.timing_one);
  endproperty
  a_write_gate: assert property (p_write_gate) else $error("timing written");

  property p_sleep_hold;
    st_reg.sleep_request && !st_reg.sleep_ack |=> st_reg.sleep_request;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("sleep request lost");

  property p_init_hold;
    st_reg.init_request && !st_reg.init_ack |=> st_reg.init_request;
  endproperty
  a_init_hold: assert property (p_init_hold) else $error("init request lost");

  property p_wake;
    wake |=> !st_reg.sleep_ack && !SLEEP_ACTIVE;
  endproperty
  a_wake: assert property (p_wake) else $error("wake ignored");

  property p_sleep_ack;
    !st_reg.sleep_request |=> !st_reg.sleep_ack;
  endproperty
  a_sleep_ack: assert property (p_sleep_ack) else $error("stale sleep ack");

  property p_jump_limit;
    st_reg.ext <= jump_q && st_reg.shrink <= jump_q;
  endproperty
  a_jump_limit: assert property (p_jump_limit) else $error("resync too large");

  sequence s_seg_one_end;
    take;
  endsequence
  sequence s_seg_two_start;
    st_reg.phase == can_timing_pkg::PH_SEG_TWO && st_reg.cnt == 5'h00 ##0 RX_BIT_VALID;
  endsequence
  property p_sample_point;
    s_seg_one_end and !fall |=> s_seg_two_start;
  endproperty
  a_sample_point: assert property (p_sample_point) else $error("sample point misplaced");

endmodule : can_bit_timing_mode_handshake
`default_nettype wire

// >>> logic/can_timing_pkg.sv
// package: register map, field layout, reset values and bit-phase type
package can_timing_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFS_CONTROL_ZERO = 8'h00;
  localparam logic [7:0] OFS_CONTROL_ONE = 8'h04;
  localparam logic [7:0] OFS_TIMING_ZERO = 8'h08;
  localparam logic [7:0] OFS_TIMING_ONE = 8'h0c;
  localparam logic [7:0] OFS_ACC_CONTROL = 8'h10;
  localparam logic [7:0] OFS_BIT_LENGTH = 8'h14;
  localparam logic [7:0] OFS_CODE_BASE = 8'h20;
  localparam logic [7:0] OFS_MASK_BASE = 8'h40;

  ////////////////////////////////////////////////////////////////////////////
  // control zero fields
  localparam int SLEEP_REQ_BIT = 0;
  localparam int INIT_REQ_BIT = 1;
  localparam int WAKEUP_EN_BIT = 2;
  // control one fields
  localparam int INIT_ACK_BIT = 0;
  localparam int SLEEP_ACK_BIT = 1;
  localparam int CLOCK_SEL_BIT = 6;
  // timing zero fields
  localparam int JUMP_MSB = 7;
  localparam int JUMP_LSB = 6;
  localparam int PRESC_MSB = 5;
  localparam int PRESC_LSB = 0;
  // timing one fields
  localparam int TRIPLE_BIT = 7;
  localparam int SEG2_MSB = 6;
  localparam int SEG2_LSB = 4;
  localparam int SEG1_MSB = 3;
  localparam int SEG1_LSB = 0;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic RESET_SLEEP_REQ = 1'b0;
  localparam logic RESET_INIT_REQ = 1'b1;
  localparam logic RESET_WAKEUP_EN = 1'b0;
  localparam logic RESET_CLOCK_SEL = 1'b0;
  localparam logic [7:0] RESET_TIMING_ZERO = 8'h00;
  localparam logic [7:0] RESET_TIMING_ONE = 8'h00;
  localparam logic [7:0] RESET_FILTER = 8'h00;
  localparam logic RECESSIVE = 1'b1;

  // phases of one bit time
  typedef enum logic [1:0] {
    PH_SYNC = 2'b00,
    PH_SEG_ONE = 2'b01,
    PH_SEG_TWO = 2'b10
  } phase_e;

endpackage : can_timing_pkg

// >>> logic/quantum_prescaler.sv
// time quantum prescaler: divides module clock enables by divide plus one
`timescale 1ns/100ps
`default_nettype none
module quantum_prescaler (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic clear,
  input wire logic mclk_en,
  input wire logic [5:0] divide,
  // quantum pulse
  output logic tq_tick
);

  typedef struct packed {
    logic [5:0] cnt;
  } state_s;

  state_s st_reg;
  state_s st_next;

  ////////////////////////////////////////////////////////////////////////////
  // count module clock enables, wrap at divide
  always_comb begin
    st_next = st_reg;
    if (clear) begin
      st_next.cnt = 6'h00;
    end else if (mclk_en) begin
      st_next.cnt = (st_reg.cnt == divide) ? 6'h00 : st_reg.cnt + 6'h01;
    end
  end

  // one pulse per divide plus one enables
  assign tq_tick = !clear && mclk_en && (st_reg.cnt == divide);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_tq_gap;
    @(posedge clk) disable iff (rst)
    tq_tick && divide != 6'h00 |=> !tq_tick;
  endproperty
  a_tq_gap: assert property (p_tq_gap) else $error("quantum pulses too close");

  property p_tq_divide;
    @(posedge clk) disable iff (rst)
    (tq_tick && divide == 6'h01) ##1 (mclk_en && !clear) [*2] |-> tq_tick;
  endproperty
  a_tq_divide: assert property (p_tq_divide) else $error("divide by two failed");

endmodule : quantum_prescaler
`default_nettype wire

// >>> sim/can_bit_timing_mode_handshake_tb.sv
// self-checking bench for bit timing and mode handshake
`timescale 1ns/100ps
`default_nettype none
module can_bit_timing_mode_handshake_tb;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, osc_tick = 0, can_rx, can_tx, tx_bit = 1, dom = 0;
  logic rx_bit, rx_valid, bit_start, init_act, sleep_act;
  logic [32:0] exp_q[$];
  logic [7:0] r;
  int error_cnt = 0, checked = 0;
  ////////////////////////////////////////////////////////////////////////////
  // 10 mhz clock and oscillator enable at half rate
  always #50 clk = ~clk;
  always @(posedge clk) osc_tick <= ~osc_tick;
  can_bit_timing_mode_handshake u_dut (.CLK(clk), .RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .OSC_TICK(osc_tick),
    .CAN_RX(can_rx), .CAN_TX(can_tx), .TX_BIT(tx_bit), .RX_BIT(rx_bit),
    .RX_BIT_VALID(rx_valid), .BIT_START(bit_start), .INIT_ACTIVE(init_act),
    .SLEEP_ACTIVE(sleep_act));
  can_bus_node u_node (.tx(can_tx), .dominant(dom), .rx(can_rx));
  ////////////////////////////////////////////////////////////////////////////
  task complete_run();
    if (error_cnt == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  task check(input string nm, input logic [32:0] s, input logic [32:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask : check
  // apb cycle; request held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      if (++n > 50) begin error_cnt++; complete_run(); end
      @(posedge clk);
    end
    psel <= 0; penable <= 0;
  endtask : apb
  // a read notes {error, data} for the monitor
  task rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(0, a, 0);
  endtask : rd
  // cycles between two bit starts, bounded
  task period(input int e);
    int n;
    n = 0;
    while (bit_start !== 1'b1 && n < 3000) begin @(negedge clk); n++; end
    if (n >= 3000) begin error_cnt++; complete_run(); end
    @(negedge clk);
    n = 1;
    while (bit_start !== 1'b1 && n < 3000) begin @(negedge clk); n++; end
    if (n >= 3000) begin error_cnt++; complete_run(); end
    check("bit_len", 33'(n), 33'(e));
  endtask : period
  // node holds a level; the sampled bit must follow it
  task sample_level(input logic lvl);
    int n;
    @(posedge clk);
    dom <= ~lvl;
    repeat (2) begin
      n = 0;
      @(negedge clk);
      while (rx_valid !== 1'b1 && n < 3000) begin @(negedge clk); n++; end
      if (n >= 3000) begin error_cnt++; complete_run(); end
    end
    check("rx_bit", {32'h0, rx_bit}, {32'h0, lvl});
  endtask : sample_level
  ////////////////////////////////////////////////////////////////////////////
  // monitor: each read answer against the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      check("rdata", {pslverr, prdata}, exp_q.pop_front());
    end
  end
  initial begin
    void'($urandom(32'h4329));
    r = 8'($urandom());
    repeat (8) @(posedge clk);
    rst <= 0;
    rd(8'h04, 33'h001);
    rd(8'h18, 33'h100000000);
    // single sampling, segment one 6 quanta, segment two 3
    apb(1, 8'h08, 32'h43);
    apb(1, 8'h0c, 32'h25);
    apb(1, 8'h20, {24'h0, r});
    rd(8'h08, 33'h43);
    rd(8'h0c, 33'h25);
    rd(8'h20, {25'h0, r});
    rd(8'h14, 33'd40);
    apb(1, 8'h00, 32'h0);
    repeat (2) @(negedge clk);
    check("init_act", {32'h0, init_act}, 33'h0);
    // writes outside init mode must be dropped
    apb(1, 8'h08, 32'hff);
    apb(1, 8'h20, {24'h0, ~r});
    rd(8'h08, 33'h43);
    rd(8'h20, {25'h0, r});
    period(80);
    sample_level(0);
    sample_level(1);
    @(posedge clk);
    tx_bit <= 0;
    repeat (3) @(negedge clk);
    check("tx_run", {32'h0, can_tx}, 33'h0);
    apb(1, 8'h00, 32'h2);
    @(negedge clk);
    check("tx_init", {32'h0, can_tx}, 33'h1);
    @(negedge clk);
    check("init_act", {32'h0, init_act}, 33'h1);
    apb(1, 8'h04, 32'h40);
    // triple sampling; segment one stays well above 2 quanta
    apb(1, 8'h0c, 32'ha5);
    rd(8'h0c, 33'ha5);
    tx_bit <= 1;
    apb(1, 8'h00, 32'h0);
    period(40);
    sample_level(0);
    sample_level(1);
    // dominant bus holds off sleep ack, so the request cannot be cleared
    @(posedge clk);
    dom <= 1;
    apb(1, 8'h00, 32'h5);
    apb(1, 8'h00, 32'h4);
    rd(8'h00, 33'h005);
    // sleep with wake-up, then bus activity wakes it
    dom <= 0;
    repeat (100) @(negedge clk);
    rd(8'h04, 33'h042);
    @(negedge clk);
    check("sleep_act", {32'h0, sleep_act}, 33'h1);
    @(posedge clk);
    dom <= 1;
    repeat (10) @(posedge clk);
    dom <= 0;
    rd(8'h04, 33'h040);
    @(negedge clk);
    check("sleep_act", {32'h0, sleep_act}, 33'h0);
    // mid-run reset returns to init mode with cleared timing
    @(posedge clk);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    rd(8'h04, 33'h001);
    rd(8'h0c, 33'h000);
    repeat (2) @(posedge clk);
    check("rd_q", 33'(exp_q.size()), 33'h0);
    complete_run();
  end
endmodule : can_bit_timing_mode_handshake_tb
`default_nettype wire

// >>> sim/can_bus_node.sv
// far side bus node: wired-and bus level seen by the block
`timescale 1ns/100ps
`default_nettype none
module can_bus_node (
  // device pin and node drive
  input wire logic tx,
  input wire logic dominant,
  // bus level
  output logic rx
);
  // dominant wins; a released bus rests recessive high
  assign rx = tx & ~dominant;
endmodule : can_bus_node
`default_nettype wire
